//--- bench/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sampleTick = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] pinIn = 16'hA5A5;
  logic [3:0] lat = 4'h1;
  logic convStart, convDone, irq;
  logic [15:0] regRdData, pinOut, pinOutEn_n;
  logic [3:0] holdStrobe;
  logic [9:0] convResult;
  conv_req_t convReq;
  int nFail = 0;
  int samplesChecked = 0;
  int nStart = 0;

  adc_conversion_sequencer i_adc_conversion_sequencer (.core_clk, .rst,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .sampleTick,
    .holdStrobe, .convStart, .convReq, .convDone, .convResult, .pinIn,
    .pinOut, .pinOutEn_n, .irq);
  conv_model i_conv_model (.core_clk, .convStart, .convReq,
    .latency(lat), .convDone, .convResult);

  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (convStart === 1'b1) nStart++;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samplesChecked++;
    if (g !== e) begin
      nFail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData & m, e);
  endtask
  task automatic res(input int i, input logic [1:0] c, input logic s,
                     input logic [3:0] n);
    rd(8'h40 + 8'(4 * i), {6'h0, 3'h5, s, c, c == 2'h0 ? n : 4'h0});
  endtask
  task automatic tick(input logic [3:0] hs);
    @(posedge core_clk);
    sampleTick <= 1'b1;
    #1 chk({12'h0, holdStrobe}, {12'h0, hs});
    @(posedge core_clk);
    sampleTick <= 1'b0;
    repeat (50) @(posedge core_clk);
  endtask
  task automatic waitIrq();
    for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge core_clk);
    chk({15'h0, irq}, 16'h0001);
    rd(`STATUS_OFS, 16'h0003, 16'h0003);
    chk({15'h0, irq}, 16'h0000);
  endtask
  task automatic setup();
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wr(`MASK_OFS, 16'h0003);
    wr(`PIN_CFG_OFS, 16'hFFFF);
    wr(`IN_SEL_OFS, 16'h0053);
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400us;
    nFail++;
    finish_test();
  end

  initial begin
    setup();
    rd(`PIN_DIR_OFS, 16'hFFFF);
    chk(pinOutEn_n, 16'hFFFF);
    rd(8'h3C, 16'h0000);
    wr(`CTRL_OFS, 16'h0000);
    tick(4'h1);
    waitIrq();
    res(0, 2'h0, 1'b0, 4'h3);
    wr(8'h40, 16'h0155);
    res(0, 2'h0, 1'b0, 4'h3);
    $display("test single done");
    lat <= 4'h5;
    wr(`CTRL_OFS, 16'h024C);
    tick(4'hF);
    chk({15'h0, irq}, 16'h0000);
    repeat (3) tick(4'hF);
    waitIrq();
    for (int i = 0; i < 16; i++) res(i, 2'(i % 4), 1'b0, 4'h3);
    $display("test simultaneous done");
    lat <= 4'h0;
    wr(`CTRL_OFS, 16'h0100);
    tick(4'h1);
    tick(4'h2);
    waitIrq();
    for (int i = 0; i < 2; i++) res(i, 2'(i), 1'b0, 4'h3);
    $display("test sequential done");
    wr(`PIN_CFG_OFS, 16'hFF0F);
    rd(`PORT_OFS, 16'h00A0);
    wr(`PIN_CFG_OFS, 16'hFFF7);
    wr(`CTRL_OFS, 16'h0000);
    nStart = 0;
    tick(4'h1);
    waitIrq();
    chk(16'(nStart), 16'h0000);
    rd(8'h40, 16'h0000);
    wr(`PIN_CFG_OFS, 16'hFFFF);
    wr(`PIN_DIR_OFS, 16'hFFF7);
    wr(`PORT_OFS, 16'h0008);
    #1 chk(pinOut, 16'h0008);
    chk(pinOutEn_n, 16'hFFF7);
    tick(4'h1);
    waitIrq();
    rd(8'h40, 16'h03FF);
    $display("test pins done");
    @(posedge core_clk);
    setup();
    wr(`CTRL_OFS, 16'h0006);
    tick(4'h1);
    chk({15'h0, irq}, 16'h0000);
    tick(4'h1);
    waitIrq();
    wr(`IN_SEL_OFS, 16'h0055);
    repeat (2) tick(4'h1);
    waitIrq();
    for (int i = 0; i < 4; i++)
      res((i / 2) * 8 + i % 2, 2'h0, 1'b0, i < 2 ? 4'h3 : 4'h5);
    $display("test split done");
    wr(`IN_SEL_OFS, 16'h0053);
    wr(`CTRL_OFS, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      tick(4'h1);
      waitIrq();
      res(0, 2'h0, i[0], i == 0 ? 4'h3 : 4'h5);
    end
    $display("test alternate done");
    wr(`SCAN_SEL_OFS, 16'h000E);
    wr(`CTRL_OFS, 16'h0404);
    for (int i = 0; i < 2; i++) begin
      repeat (2) tick(4'h1);
      waitIrq();
      res(0, 2'h0, 1'b0, 4'h1);
      res(1, 2'h0, 1'b0, 4'h2);
    end
    $display("test scan done");
    finish_test();
  end
endmodule

//--- bench/conv_model.sv
`timescale 1ns/1ps
module conv_model (
  input wire logic core_clk, // clock
  input wire logic convStart, // conversion request
  input wire adc_seq_pkg::conv_req_t convReq, // channel and input
  input wire logic [3:0] latency, // answer delay in cycles
  output logic convDone, // finished pulse
  output logic [9:0] convResult // result, valid with convDone
);
  import adc_seq_pkg::*;
  conv_req_t held;
  logic [3:0] cnt = 4'h0;
  logic busy = 1'b0;
  initial convDone = 1'b0;
  initial convResult = 10'h000;
  always @(posedge core_clk) begin
    convDone <= 1'b0;
    if (convStart) begin
      held <= convReq;
      cnt <= latency;
      busy <= 1'b1;
    end else if (busy && cnt == 4'h0) begin
      convDone <= 1'b1;
      convResult <= {3'h5, held.setSecond, held.chan,
                     held.chan == 2'h0 ? held.holdZeroInput : 4'h0};
      busy <= 1'b0;
    end else begin
      cnt <= cnt - 4'h1;
      // no stale value between answers
      convResult <= ~convResult;
    end
  end
endmodule

//--- rtl/adc_conversion_sequencer.sv
// Notes on behaviour
// - without simultaneous sampling, each enabled channel takes its own tick.
// - with simultaneous sampling, all enabled channels hold on one tick.
// - channel count enables channel zero, zero and one, or zero to three.
// - interrupt follows samples_per_interrupt plus one completed sequences.
// - split mode uses two 8-word halves, swapping half on each interrupt.
// - without split mode the whole 16-word buffer is filled.
// - samples_per_interrupt sits in control bits 5:2 as count minus one.
// - alternate select clear uses only the first input set.
// - alternate select set swaps input sets on successive sequences.
// - scan enable steps channel zero over scan-selected first-set inputs.
// - scan goes upward and restarts at lowest selected input per interrupt.
// - excess selected scan inputs stay unconverted in that interval.
// - port read gives zero on every analog-configured pin.
// - digital pins are not converted; analog output pins store driven level unconverted.
// - on interrupt, flag and done status bits both set.
// - sixteen 10-bit result entries, readable, never written by software.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_conversion_sequencer #(
  parameter int BUF_DEPTH = 16,
  parameter int RES_W = 10
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // async reset, high
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [15:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [15:0] regRdData, // read data, cycle after strobe
  input wire logic sampleTick, // sample clock pulse
  output logic [3:0] holdStrobe, // sample/hold capture per channel
  output logic convStart, // conversion request pulse
  output adc_seq_pkg::conv_req_t convReq, // channel and input selection
  input wire logic convDone, // conversion finished pulse
  input wire logic [9:0] convResult, // converter result
  input wire logic [15:0] pinIn, // pin levels
  output logic [15:0] pinOut, // driven pin levels
  output logic [15:0] pinOutEn_n, // low while driving
  output logic irq // conversion interrupt level
);
  import adc_seq_pkg::*;

  if (BUF_DEPTH != 16 || RES_W != 10) begin : gSizeCheck
    $error("buffer must be 16 entries of 10 bits");
  end

  logic [15:0] ctrl_q;
  logic [15:0] scanSel_q;
  logic [1:0] mask_q;
  logic [15:0] pinCfg_q;
  logic [15:0] pinDir_q;
  logic [15:0] port_q;
  logic [7:0] inSel_q;
  logic irqFlag_q;
  logic done_q;
  logic [15:0] rdData_q;
  seq_state_t state_q;
  logic [1:0] chIdx_q;
  logic [3:0] seqCnt_q;
  logic setSecond_q;
  logic [3:0] scanPos_q;
  logic scanRestart_q;
  logic [3:0] wrPtr_q;
  logic half_q;
  logic [9:0] resultBuf [BUF_DEPTH];

  logic altSel, splitMode, simul, scanEn;
  logic [3:0] seqPerIrq;
  logic [1:0] lastCh;
  logic [3:0] enMask;
  logic [3:0] holdZeroIn, scanCur;
  logic skipConv;
  logic [9:0] skipVal;
  logic storeEn;
  logic [9:0] storeVal;
  logic seqDone;
  logic intrEvent;
  logic rdStatus;

  function automatic logic [3:0] firstFrom(input logic [15:0] m,
                                           input logic [4:0] from);
    logic [3:0] r;
    logic hit;
    r = 4'h0;
    hit = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && i >= int'(from)) begin
        r = 4'(i);
        hit = 1'b1;
      end
    end
    if (!hit) begin
      for (int i = 15; i >= 0; i--) begin
        if (m[i]) begin
          r = 4'(i);
        end
      end
    end
    return r;
  endfunction

  assign altSel = ctrl_q[`ALT_BIT];
  assign splitMode = ctrl_q[`SPLIT_BIT];
  assign seqPerIrq = ctrl_q[`SEQ_CNT_MSB:`SEQ_CNT_LSB];
  assign simul = ctrl_q[`SIMUL_BIT];
  assign scanEn = ctrl_q[`SCAN_BIT];

  always_comb begin
    case (ctrl_q[`CHAN_CNT_MSB:`CHAN_CNT_LSB])
      2'h0: lastCh = 2'h0;
      2'h1: lastCh = 2'h1;
      default: lastCh = 2'h3;
    endcase
  end
  assign enMask = (lastCh == 2'h0) ? 4'h1 :
                  (lastCh == 2'h1) ? 4'h3 : 4'hF;

  // channel zero input: scan position only on the first set
  assign scanCur = scanRestart_q ? firstFrom(scanSel_q, 5'h00) :
                   scanPos_q;
  assign holdZeroIn = setSecond_q ? inSel_q[7:4] :
                      (scanEn ? scanCur : inSel_q[3:0]);

  assign convReq.chan = chIdx_q;
  assign convReq.holdZeroInput = holdZeroIn;
  assign convReq.setSecond = setSecond_q;

  // channel zero on a digital pin is stored as zero; analog output pin
  // reports its driven level
  always_comb begin
    skipConv = 1'b0;
    skipVal = 10'h000;
    if (chIdx_q == 2'h0) begin
      if (!pinCfg_q[holdZeroIn]) begin
        skipConv = 1'b1;
      end else if (!pinDir_q[holdZeroIn]) begin
        skipConv = 1'b1;
        skipVal = {10{port_q[holdZeroIn]}};
      end
    end
  end

  assign holdStrobe = (state_q == IDLE && sampleTick) ?
                      (simul ? enMask : (4'h1 << chIdx_q)) : 4'h0;
  assign convStart = (state_q == CONV_REQ) && !skipConv;

  assign storeEn = (state_q == CONV_REQ && skipConv) ||
                   (state_q == CONV_WAIT && convDone);
  assign storeVal = (state_q == CONV_WAIT) ? convResult : skipVal;
  assign seqDone = storeEn && (chIdx_q == lastCh);
  assign intrEvent = seqDone && (seqCnt_q == seqPerIrq);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IDLE;
      chIdx_q <= 2'h0;
    end else begin
      case (state_q)
        IDLE: begin
          if (sampleTick) begin
            state_q <= CONV_REQ;
          end
        end
        CONV_REQ: begin
          if (skipConv) begin
            chIdx_q <= (chIdx_q == lastCh) ? 2'h0 : chIdx_q + 2'h1;
            // simultaneous: remaining channels already held
            state_q <= (chIdx_q != lastCh && simul) ? CONV_REQ : IDLE;
          end else begin
            state_q <= CONV_WAIT;
          end
        end
        CONV_WAIT: begin
          if (convDone) begin
            chIdx_q <= (chIdx_q == lastCh) ? 2'h0 : chIdx_q + 2'h1;
            state_q <= (chIdx_q != lastCh && simul) ? CONV_REQ : IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seqCnt_q <= 4'h0;
      setSecond_q <= 1'b0;
      scanPos_q <= 4'h0;
      scanRestart_q <= 1'b1;
    end else begin
      scanRestart_q <= (regWr && (regAddr == `CTRL_OFS ||
                       regAddr == `SCAN_SEL_OFS)) ||
                       (scanRestart_q && !(seqDone && !setSecond_q));
      if (seqDone) begin
        seqCnt_q <= intrEvent ? 4'h0 : seqCnt_q + 4'h1;
        setSecond_q <= altSel ? !setSecond_q : 1'b0;
        if (intrEvent) begin
          scanPos_q <= firstFrom(scanSel_q, 5'h00);
        end else if (!setSecond_q) begin
          scanPos_q <= firstFrom(scanSel_q, 5'(scanCur) + 5'h01);
        end
      end
      if (!altSel) begin
        setSecond_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 4'h0;
      half_q <= 1'b0;
    end else if (intrEvent) begin
      half_q <= splitMode ? !half_q : 1'b0;
      wrPtr_q <= splitMode ? {!half_q, 3'h0} : 4'h0;
    end else if (storeEn) begin
      wrPtr_q <= splitMode ? {half_q, wrPtr_q[2:0] + 3'h1} :
                 wrPtr_q + 4'h1;
    end
  end

  // only the sequencer writes entries
  always_ff @(posedge core_clk) begin
    if (storeEn) begin
      resultBuf[wrPtr_q] <= storeVal;
    end
  end

  assign rdStatus = regRd && regAddr == `STATUS_OFS;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqFlag_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (intrEvent) begin
        irqFlag_q <= 1'b1;
        done_q <= 1'b1;
      end else if (rdStatus) begin
        irqFlag_q <= 1'b0;
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
      scanSel_q <= `SCAN_SEL_RST;
      mask_q <= `MASK_RST;
      pinCfg_q <= `PIN_CFG_RST;
      pinDir_q <= `PIN_DIR_RST;
      port_q <= `PORT_RST;
      inSel_q <= `IN_SEL_RST;
    end else if (regWr) begin
      case (regAddr)
        `CTRL_OFS: ctrl_q <= regWrData;
        `SCAN_SEL_OFS: scanSel_q <= regWrData;
        `MASK_OFS: mask_q <= regWrData[1:0];
        `PIN_CFG_OFS: pinCfg_q <= regWrData;
        `PIN_DIR_OFS: pinDir_q <= regWrData;
        `PORT_OFS: port_q <= regWrData;
        `IN_SEL_OFS: inSel_q <= regWrData[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 16'h0000;
    end else if (regRd) begin
      if (regAddr[7:6] == `RESULT_BASE_HI) begin
        rdData_q <= {6'h00, resultBuf[regAddr[5:2]]};
      end else begin
        case (regAddr)
          `CTRL_OFS: rdData_q <= ctrl_q;
          `SCAN_SEL_OFS: rdData_q <= scanSel_q;
          `STATUS_OFS: rdData_q <= {11'h000, half_q, wrPtr_q[3:2] == 2'h0,
                                    state_q != IDLE, done_q, irqFlag_q};
          `MASK_OFS: rdData_q <= {14'h0000, mask_q};
          `PIN_CFG_OFS: rdData_q <= pinCfg_q;
          `PIN_DIR_OFS: rdData_q <= pinDir_q;
          `PORT_OFS: rdData_q <= pinIn & ~pinCfg_q;
          `IN_SEL_OFS: rdData_q <= {8'h00, inSel_q};
          default: rdData_q <= 16'h0000;
        endcase
      end
    end else begin
      rdData_q <= 16'h0000;
    end
  end

  assign regRdData = rdData_q;
  assign pinOut = port_q;
  assign pinOutEn_n = pinDir_q;
  assign irq = (irqFlag_q & mask_q[`IRQ_FLAG_BIT]) |
               (done_q & mask_q[`DONE_BIT]);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  seq_hold_a: assert property (holdStrobe != 4'h0 && !simul |->
    $onehot(holdStrobe)) else $error("sequential hold not one channel");
  sim_hold_a: assert property (holdStrobe != 4'h0 && simul |->
    holdStrobe == enMask) else $error("simultaneous hold incomplete");
  chan_limit_a: assert property (convStart |-> convReq.chan <= lastCh)
    else $error("conversion on disabled channel");
  irq_status_a: assert property (intrEvent |=> irqFlag_q && done_q &&
    seqCnt_q == 4'h0) else $error("interrupt status not set");
  split_swap_a: assert property (intrEvent && splitMode |=>
    half_q != $past(half_q) && wrPtr_q == {half_q, 3'h0})
    else $error("half not swapped");
  full_step_a: assert property (storeEn && !intrEvent && !splitMode |=>
    wrPtr_q == $past(wrPtr_q) + 4'h1) else $error("pointer not stepped");
  first_set_a: assert property (!altSel |=> !setSecond_q)
    else $error("second set used while not alternating");
  alt_swap_a: assert property (seqDone && altSel && $stable(altSel) |=>
    setSecond_q != $past(setSecond_q)) else $error("set not swapped");
  scan_restart_a: assert property (intrEvent |=>
    scanPos_q == firstFrom($past(scanSel_q), 5'h00))
    else $error("scan not restarted at lowest");
  port_mask_a: assert property (regRd && regAddr == `PORT_OFS |=>
    (regRdData & $past(pinCfg_q)) == 16'h0000)
    else $error("analog pin read nonzero");
  digital_skip_a: assert property (state_q == CONV_REQ && chIdx_q == 2'h0 &&
    !pinCfg_q[holdZeroIn] |-> !convStart)
    else $error("digital pin converted");
  ptr_restart_a: assert property (intrEvent |=> wrPtr_q[2:0] == 3'h0)
    else $error("pointer not restarted");
endmodule

//--- rtl/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// register byte offsets
`define CTRL_OFS 8'h00
`define SCAN_SEL_OFS 8'h04
`define STATUS_OFS 8'h08
`define MASK_OFS 8'h0C
`define PIN_CFG_OFS 8'h10
`define PIN_DIR_OFS 8'h14
`define PORT_OFS 8'h18
`define IN_SEL_OFS 8'h1C
`define RESULT_BASE_HI 2'h1

// control register fields
`define ALT_BIT 0
`define SPLIT_BIT 1
`define SEQ_CNT_LSB 2
`define SEQ_CNT_MSB 5
`define SIMUL_BIT 6
`define CHAN_CNT_LSB 8
`define CHAN_CNT_MSB 9
`define SCAN_BIT 10

// status and mask fields
`define IRQ_FLAG_BIT 0
`define DONE_BIT 1

// reset values
`define CTRL_RST 16'h0000
`define SCAN_SEL_RST 16'h0000
`define MASK_RST 2'h0
`define PIN_CFG_RST 16'h0000
`define PIN_DIR_RST 16'hFFFF
`define PORT_RST 16'h0000
`define IN_SEL_RST 8'h00

`endif

//--- rtl/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef struct packed {
    logic [1:0] chan;
    logic [3:0] holdZeroInput;
    logic setSecond;
  } conv_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wrData;
  } unused_pad_t;

  typedef enum {IDLE, CONV_REQ, CONV_WAIT} seq_state_t;

endpackage
